// File: hw/dis_i2c_slave.sv
// dis_i2c_slave.sv: i2c slave front end with staged register writes and readback
// assumes scl and sda arrive from pads, register file and clear logic sit outside
//
// Overview of operation
// RULE_01 - channel six code writes accepted unless channel held in reset mode
// RULE_02 - slave only; scl is never driven, master limits it to 400kHz
// RULE_03 - sda changes only while scl low, except start and stop
// RULE_04 - bytes are eight bits, ninth clock is the acknowledge slot
// RULE_05 - start is sda falling, stop sda rising, both with scl high
// RULE_06 - sda is open drain: pulled low or released, never driven high
// RULE_07 - watch for start plus address byte; eighth bit one means read
// RULE_08 - own address is 10110 plus the two address select pins
// RULE_09 - repeated start drops staged data, no register changes
// RULE_10 - command byte follows address; two data bytes follow in writes
// RULE_11 - data staged, copied to target only during the acknowledge slot
// RULE_12 - register address is command bits seven to one, lsb ignored
// RULE_13 - stop anywhere ends transfer and drops an incomplete write group
// RULE_14 - stop in readback ends it; next read restarts at first byte
// RULE_15 - master writes start, address, command, high, low, stop
// RULE_16 - any number of command and data groups per write transfer
// RULE_17 - read returns bits fifteen to eight, then seven to zero
// RULE_18 - extra read bytes return zero
// RULE_19 - clear input never disturbs the serial interface or readback
// RULE_20 - foreign address: no acknowledge, ignore bus until next start
// RULE_21 - acknowledge own address and every byte received while addressed
`timescale 1ns/1ps
module dis_i2c_slave (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_scl,
    input  wire logic        i_sda_in,
    output logic             o_sda_out,
    output logic             o_sda_oe,
    input  wire logic        i_addr_select_hi_pin,
    input  wire logic        i_addr_select_lo_pin,
    input  wire logic        i_ch6_reset_hold,
    output logic             o_wr_en,
    output logic      [6:0]  o_wr_addr,
    output logic      [15:0] o_wr_data,
    output logic      [6:0]  o_rd_addr,
    input  wire logic [15:0] i_rd_data
);

    dis_pkg::dis_slave_type q;
    dis_pkg::dis_slave_type next_q;

    logic                          link_bit;
    logic [dis_pkg::SYNC_WIDTH-1:0] sync_in;
    logic [dis_pkg::SYNC_WIDTH-1:0] sync_out;
    logic                          scl_s;
    logic                          sda_s;
    logic                          bit_s;
    logic                          hold_s;
    logic [6:0]                    own_addr;
    logic                          scl_rise;
    logic                          scl_fall;
    logic                          start_cond;
    logic                          stop_cond;
    logic                          bit_take;
    logic                          byte_done;
    logic                          ack_clock;
    logic                          active;
    logic [7:0]                    rx_byte;
    logic                          ch6_code;

    // ==========================================================
    // link domain
    // scl is only ever an input here, the master owns the clock
    always_ff @(posedge i_scl) begin
        link_bit <= i_sda_in; // RULE_02
    end

    // ==========================================================
    // crossings into the system clock
    // the sampled bit holds for a whole scl period, so a level sync is enough
    assign sync_in = {i_ch6_reset_hold, i_addr_select_lo_pin, i_addr_select_hi_pin,
                      link_bit, i_sda_in, i_scl};

    dis_sync #(
        .WIDTH       (dis_pkg::SYNC_WIDTH),
        .RESET_VALUE (dis_pkg::SYNC_RESET)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async (sync_in),
        .o_sync  (sync_out)
    );

    assign scl_s    = sync_out[dis_pkg::SYNC_SCL];
    assign sda_s    = sync_out[dis_pkg::SYNC_SDA];
    assign bit_s    = sync_out[dis_pkg::SYNC_BIT];
    assign hold_s   = sync_out[dis_pkg::SYNC_HOLD];
    assign own_addr = {dis_pkg::ADDR_FIXED, sync_out[dis_pkg::SYNC_A_HI],
                       sync_out[dis_pkg::SYNC_A_LO]}; // RULE_08

    // ==========================================================
    // bus events
    assign scl_rise   = scl_s & ~q.scl_prev;
    assign scl_fall   = ~scl_s & q.scl_prev;
    assign start_cond = scl_s & q.scl_prev & q.sda_prev & ~sda_s; // RULE_05
    assign stop_cond  = scl_s & q.scl_prev & ~q.sda_prev & sda_s; // RULE_05
    // wait until the link sample has passed its synchroniser
    assign bit_take   = (q.delay_cnt == dis_pkg::DELAY_LAST);
    assign active     = (q.st != dis_pkg::st_idle) && (q.st != dis_pkg::st_ignore);
    assign byte_done  = bit_take && active && (q.bitcnt == dis_pkg::BIT_LAST);
    assign ack_clock  = bit_take && active && (q.bitcnt == dis_pkg::ACK_SLOT); // RULE_04
    assign rx_byte    = {q.rx[6:0], bit_s};
    assign ch6_code   = (q.cmd == dis_pkg::REG_CH6_SOURCE) || (q.cmd == dis_pkg::REG_CH6_SINK)
                        || (q.cmd == dis_pkg::REG_CH6_SHUTTER);

    // ==========================================================
    // protocol engine
    always_comb begin
        next_q          = q;
        next_q.wr_en    = 1'h0;
        next_q.sda_out  = 1'h0; // RULE_06
        next_q.scl_prev = scl_s;
        next_q.sda_prev = sda_s;
        if (stop_cond) begin
            // an unfinished group never reaches the register file
            next_q.st        = dis_pkg::st_idle; // RULE_13 RULE_14
            next_q.bitcnt    = dis_pkg::BIT_FIRST;
            next_q.ack       = 1'h0;
            next_q.commit    = 1'h0;
            next_q.sda_oe    = 1'h0;
            next_q.delay_cnt = 2'h0;
        end else if (start_cond) begin
            next_q.st        = dis_pkg::st_addr; // RULE_07 RULE_09
            next_q.bitcnt    = dis_pkg::BIT_FIRST;
            next_q.ack       = 1'h0;
            next_q.commit    = 1'h0;
            next_q.sda_oe    = 1'h0;
            next_q.delay_cnt = 2'h0;
        end else begin
            if (scl_rise) begin
                next_q.delay_cnt = dis_pkg::SAMPLE_DELAY;
            end else if (q.delay_cnt != 2'h0) begin
                next_q.delay_cnt = q.delay_cnt - dis_pkg::DELAY_STEP;
            end
            if (ack_clock) begin
                next_q.bitcnt = dis_pkg::BIT_FIRST;
                next_q.ack    = 1'h0;
                if (q.commit) begin
                    next_q.commit = 1'h0;
                    // clear only acts through the hold level, never on the bus side
                    if (!(ch6_code && hold_s)) begin // RULE_01 RULE_19
                        next_q.wr_en   = 1'h1; // RULE_11
                        next_q.wr_addr = q.cmd;
                        next_q.wr_data = q.stage;
                    end
                end
                if (q.st == dis_pkg::st_read) begin
                    if (bit_s) begin
                        // master nack: stop driving until the next start
                        next_q.st = dis_pkg::st_ignore;
                    end else begin
                        case (q.rd_idx)
                            dis_pkg::RD_NONE: next_q.tx = q.rd_word[15:8]; // RULE_17
                            dis_pkg::RD_HI:   next_q.tx = q.rd_word[7:0]; // RULE_17
                            default:          next_q.tx = 8'h00; // RULE_18
                        endcase
                        if (q.rd_idx != dis_pkg::RD_PAST) begin
                            next_q.rd_idx = q.rd_idx + dis_pkg::RD_STEP;
                        end
                    end
                end
            end else if (bit_take && active) begin
                next_q.rx     = rx_byte;
                next_q.bitcnt = q.bitcnt + dis_pkg::BIT_STEP;
                if (byte_done) begin
                    case (q.st)
                        dis_pkg::st_addr: begin
                            if (rx_byte[7:1] == own_addr) begin // RULE_08
                                next_q.ack = 1'h1; // RULE_21
                                if (rx_byte[0] == dis_pkg::DIR_READ) begin // RULE_07
                                    next_q.st      = dis_pkg::st_read; // RULE_14
                                    next_q.rd_idx  = dis_pkg::RD_NONE;
                                    next_q.rd_word = i_rd_data;
                                end else begin
                                    next_q.st = dis_pkg::st_cmd;
                                end
                            end else begin
                                next_q.st = dis_pkg::st_ignore; // RULE_20
                            end
                        end
                        dis_pkg::st_cmd: begin
                            next_q.cmd = rx_byte[7:1]; // RULE_12
                            next_q.ack = 1'h1; // RULE_21
                            next_q.st  = dis_pkg::st_data_hi; // RULE_10
                        end
                        dis_pkg::st_data_hi: begin
                            next_q.stage[15:8] = rx_byte; // RULE_11
                            next_q.ack         = 1'h1;
                            next_q.st          = dis_pkg::st_data_lo;
                        end
                        dis_pkg::st_data_lo: begin
                            next_q.stage[7:0] = rx_byte; // RULE_11
                            next_q.ack        = 1'h1;
                            next_q.commit     = 1'h1;
                            next_q.st         = dis_pkg::st_cmd; // RULE_16 RULE_15
                        end
                        default: begin
                            next_q.ack = 1'h0;
                        end
                    endcase
                end
            end
            // the pin only moves just after scl falls
            if (scl_fall) begin // RULE_03
                if (q.bitcnt == dis_pkg::ACK_SLOT) begin
                    next_q.sda_oe = q.ack; // RULE_21
                end else if (q.st == dis_pkg::st_read) begin
                    next_q.sda_oe = ~q.tx[dis_pkg::BIT_LAST[2:0] - q.bitcnt[2:0]]; // RULE_06
                end else begin
                    next_q.sda_oe = 1'h0;
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            q <= dis_pkg::SLAVE_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign o_sda_out = q.sda_out;
    assign o_sda_oe  = q.sda_oe;
    assign o_wr_en   = q.wr_en;
    assign o_wr_addr = q.wr_addr;
    assign o_wr_data = q.wr_data;
    assign o_rd_addr = q.cmd;

    // ==========================================================
    // checks
    default clocking dis_cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_ch6_gate: assert property ( // RULE_01
        q.wr_en && ((q.wr_addr == dis_pkg::REG_CH6_SOURCE) || (q.wr_addr == dis_pkg::REG_CH6_SINK)
        || (q.wr_addr == dis_pkg::REG_CH6_SHUTTER)) |-> !$past(hold_s))
        else $error("channel six code written while held in reset");

    a_oe_scl_low: assert property ( // RULE_03
        $rose(q.sda_oe) |-> !$past(scl_s))
        else $error("sda pulled low while scl high");

    a_slot_width: assert property ( // RULE_04
        q.bitcnt <= dis_pkg::ACK_SLOT)
        else $error("bit counter beyond acknowledge slot");

    a_drive_scope: assert property ( // RULE_06
        q.sda_oe |-> (q.st != dis_pkg::st_idle) && (q.st != dis_pkg::st_ignore) && !q.sda_out)
        else $error("sda driven outside an addressed transfer");

    a_addr_ack: assert property ( // RULE_08
        byte_done && (q.st == dis_pkg::st_addr) && (rx_byte[7:1] == own_addr)
        |=> q.ack && (q.st != dis_pkg::st_ignore))
        else $error("own address not acknowledged");

    a_start_drop: assert property ( // RULE_09
        start_cond |=> (q.st == dis_pkg::st_addr) && !q.commit && !q.wr_en
        && (q.bitcnt == dis_pkg::BIT_FIRST))
        else $error("repeated start kept staged data");

    a_commit_slot: assert property ( // RULE_11
        q.wr_en |-> $past(q.bitcnt) == dis_pkg::ACK_SLOT ##1 !q.wr_en)
        else $error("register write outside acknowledge slot");

    a_cmd_field: assert property ( // RULE_12
        byte_done && (q.st == dis_pkg::st_cmd) |=> q.cmd == $past(rx_byte[7:1]))
        else $error("command byte not decoded from upper bits");

    a_stop_end: assert property ( // RULE_13
        stop_cond |=> (q.st == dis_pkg::st_idle) && !q.commit && !q.sda_oe)
        else $error("stop did not end the transfer");

    a_read_restart: assert property ( // RULE_14
        byte_done && (q.st == dis_pkg::st_addr) && (rx_byte[7:1] == own_addr) && rx_byte[0]
        |=> (q.rd_idx == dis_pkg::RD_NONE) && (q.rd_word == $past(i_rd_data)))
        else $error("readback did not restart at the first byte");

    a_group_repeat: assert property ( // RULE_16
        byte_done && (q.st == dis_pkg::st_data_lo) |=> (q.st == dis_pkg::st_cmd) && q.commit)
        else $error("write group did not return to command byte");

    a_read_order: assert property ( // RULE_17
        ack_clock && (q.st == dis_pkg::st_read) && !bit_s && (q.rd_idx == dis_pkg::RD_NONE)
        |=> q.tx == q.rd_word[15:8])
        else $error("readback high byte not sent first");

    a_read_zero: assert property ( // RULE_18
        (q.st == dis_pkg::st_read) && (q.rd_idx == dis_pkg::RD_PAST) |-> q.tx == 8'h00)
        else $error("extra readback byte not zero");

    a_addr_miss: assert property ( // RULE_20
        byte_done && (q.st == dis_pkg::st_addr) && (rx_byte[7:1] != own_addr)
        |=> (q.st == dis_pkg::st_ignore) && !q.ack)
        else $error("foreign address not ignored");

    a_ack_drive: assert property ( // RULE_21
        scl_fall && !start_cond && !stop_cond && (q.bitcnt == dis_pkg::ACK_SLOT) && q.ack
        |=> q.sda_oe)
        else $error("acknowledge not driven");

endmodule

// File: hw/dis_pkg.sv
// dis_pkg.sv: constants and types of the dac i2c slave register port
// assumes a 100 MHz system clock and an external master driving scl at up to 400 kHz
package dis_pkg;

    // ==========================================================
    // timing
    localparam int         CLK_PERIOD_PS    = 10000;
    localparam int         SAMPLE_DELAY_NS  = 30;
    // least time, so round up to whole cycles
    localparam int         SAMPLE_DELAY_CYC = (SAMPLE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
    localparam logic [1:0] SAMPLE_DELAY     = 2'(SAMPLE_DELAY_CYC);
    localparam logic [1:0] DELAY_LAST       = 2'h1;
    localparam logic [1:0] DELAY_STEP       = 2'h1;

    // ==========================================================
    // synchroniser lanes
    localparam int         SYNC_WIDTH = 6;
    localparam int         SYNC_SCL   = 0;
    localparam int         SYNC_SDA   = 1;
    localparam int         SYNC_BIT   = 2;
    localparam int         SYNC_A_HI  = 3;
    localparam int         SYNC_A_LO  = 4;
    localparam int         SYNC_HOLD  = 5;
    // idle bus lines are high, so scl and sda lanes come out of reset high
    localparam logic [5:0] SYNC_RESET = 6'h03;

    // ==========================================================
    // bus framing
    localparam logic [4:0] ADDR_FIXED = 5'h16;
    localparam logic       DIR_READ   = 1'h1;
    localparam logic [3:0] BIT_FIRST  = 4'h0;
    localparam logic [3:0] BIT_LAST   = 4'h7;
    localparam logic [3:0] ACK_SLOT   = 4'h8;
    localparam logic [3:0] BIT_STEP   = 4'h1;

    // ==========================================================
    // channel six code registers
    localparam logic [6:0] REG_CH6_SOURCE  = 7'h16;
    localparam logic [6:0] REG_CH6_SINK    = 7'h1a;
    localparam logic [6:0] REG_CH6_SHUTTER = 7'h1b;

    // ==========================================================
    // readback byte count
    localparam logic [1:0] RD_NONE = 2'h0;
    localparam logic [1:0] RD_HI   = 2'h1;
    localparam logic [1:0] RD_PAST = 2'h3;
    localparam logic [1:0] RD_STEP = 2'h1;

    // ==========================================================
    // state
    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_cmd,
        st_data_hi,
        st_data_lo,
        st_read,
        st_ignore
    } dis_state_type;

    typedef struct packed {
        dis_state_type st;
        logic          scl_prev;
        logic          sda_prev;
        logic [1:0]    delay_cnt;
        logic [3:0]    bitcnt;
        logic [7:0]    rx;
        logic          ack;
        logic          commit;
        logic [6:0]    cmd;
        logic [15:0]   stage;
        logic [15:0]   rd_word;
        logic [1:0]    rd_idx;
        logic [7:0]    tx;
        logic          sda_oe;
        logic          sda_out;
        logic          wr_en;
        logic [6:0]    wr_addr;
        logic [15:0]   wr_data;
    } dis_slave_type;

    localparam dis_slave_type SLAVE_RESET = '{
        st:        st_idle,
        scl_prev:  1'h1,
        sda_prev:  1'h1,
        delay_cnt: 2'h0,
        bitcnt:    4'h0,
        rx:        8'h00,
        ack:       1'h0,
        commit:    1'h0,
        cmd:       7'h00,
        stage:     16'h0000,
        rd_word:   16'h0000,
        rd_idx:    2'h0,
        tx:        8'h00,
        sda_oe:    1'h0,
        sda_out:   1'h0,
        wr_en:     1'h0,
        wr_addr:   7'h00,
        wr_data:   16'h0000
    };

endpackage

// File: hw/dis_sync.sv
// dis_sync.sv: two flip-flop synchroniser for a bundle of independent levels
// assumes every lane is a level that stays put for many system clock cycles
`timescale 1ns/1ps
module dis_sync #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } dis_sync_state_type;

    dis_sync_state_type q;
    dis_sync_state_type next_q;

    // ==========================================================
    // stages
    // the first stage feeds only the second one
    always_comb begin
        next_q      = q;
        next_q.meta = i_async;
        next_q.sync = q.meta;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            q <= '{meta: RESET_VALUE, sync: RESET_VALUE};
        end else begin
            q <= next_q;
        end
    end

    assign o_sync = q.sync;

endmodule

// File: verification/dac_i2c_slave_register_port_bench.sv
// dac_i2c_slave_register_port_bench.sv: self-checking bench of the i2c slave
// assumes dis_master_model drives the link; register file modelled here
`timescale 1ns/1ps
module dac_i2c_slave_register_port_bench;
    logic        i_clock = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        scl, m_low, sda, sda_oe, sda_out, a_hi, a_lo, hold, wr_en;
    logic [6:0]  wr_addr, rd_addr;
    logic [15:0] wr_data;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          seed = 32'h498c;
    logic [22:0] got[$];
    logic [22:0] want[$];

    // bit eleven set so a cut-short read leaves sda free for stop
    function automatic logic [15:0] rd_val(input logic [6:0] ra);
        return {4'h9, 1'b1, ra, 4'h3};
    endfunction

    always #5 i_clock = !i_clock;
    assign sda = !(m_low || sda_oe);

    dis_i2c_slave uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(scl),
        .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_addr_select_hi_pin(a_hi), .i_addr_select_lo_pin(a_lo),
        .i_ch6_reset_hold(hold), .o_wr_en(wr_en), .o_wr_addr(wr_addr),
        .o_wr_data(wr_data), .o_rd_addr(rd_addr), .i_rd_data(rd_val(rd_addr)));
    dis_master_model m (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));

    // ==========================================================
    // checks
    task automatic cmp(input string what, input logic [22:0] exp, input logic [22:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // outputs are looked at mid-cycle, well clear of the edge that launches them
    always @(negedge i_clock) begin
        if (wr_en === 1'b1) got.push_back({wr_addr, wr_data});
        if (i_rst_n && sda_oe === 1'b1) cmp("sda_out", 23'h0, 23'(sda_out));
    end
    always @(sda_oe) if (i_rst_n === 1'b1 && scl === 1'b1) cmp("oe_scl_high", 23'h0, 23'h1);

    task automatic addr(input logic [1:0] sel, input logic rd, input logic exp_ack);
        logic a;
        m.start();
        m.send({5'h16, sel, rd}, 8, a);
        cmp("addr_ack", 23'(exp_ack), 23'(a));
    endtask

    task automatic group(input logic [6:0] ra, input logic [15:0] d, input logic keep);
        logic a;
        m.send({ra, 1'($random(seed))}, 8, a);
        cmp("cmd_ack", 23'h1, 23'(a));
        m.send(d[15:8], 8, a);
        cmp("hi_ack", 23'h1, 23'(a));
        m.send(d[7:0], 8, a);
        cmp("data_ack", 23'h1, 23'(a));
        if (keep) want.push_back({ra, d});
    endtask

    task automatic settle(input string name);
        repeat (20) @(negedge i_clock);
        cmp("commit_count", 23'(want.size()), 23'(got.size()));
        while (want.size() > 0 && got.size() > 0) cmp("commit", want.pop_front(), got.pop_front());
        want.delete();
        got.delete();
        $display("test %s done", name);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    initial begin
        logic [7:0] b;
        logic [6:0] ra;
        logic       a;
        {a_hi, a_lo, hold} = 3'h0;
        repeat (8) @(negedge i_clock);
        i_rst_n = 1'b1;
        repeat (8) @(negedge i_clock);
        for (int s = 0; s < 4; s++) begin
            {a_hi, a_lo} = 2'(s);
            repeat (4) @(negedge i_clock);
            addr(2'(s), 1'b0, 1'b1);
            group(7'($random(seed)), 16'($random(seed)), 1'b1);
            m.stop();
            addr(2'(s + 1), 1'b0, 1'b0);
            m.send(8'h22, 8, a);
            cmp("foreign_ack", 23'h0, 23'(a));
            m.stop();
            settle("address");
        end
        addr(2'h3, 1'b0, 1'b1);
        for (int g = 0; g < 3; g++) group(7'($random(seed)), 16'($random(seed)), 1'b1);
        m.stop();
        settle("multi");
        addr(2'h3, 1'b0, 1'b1);
        group(7'h05, 16'h1234, 1'b1);
        m.send(8'h0a, 8, a);
        m.send(8'hff, 8, a);
        m.send(8'h00, 5, a);
        m.stop();
        addr(2'h3, 1'b0, 1'b1);
        m.send(8'h0c, 8, a);
        m.send(8'h55, 8, a);
        addr(2'h3, 1'b0, 1'b1);
        m.stop();
        settle("abort");
        for (int h = 1; h >= 0; h--) begin
            hold = h[0];
            repeat (4) @(negedge i_clock);
            addr(2'h3, 1'b0, 1'b1);
            group(dis_pkg::REG_CH6_SOURCE, 16'h0101, !hold);
            group(dis_pkg::REG_CH6_SINK, 16'h0202, !hold);
            group(dis_pkg::REG_CH6_SHUTTER, 16'h0303, !hold);
            group(7'h15, 16'h0404, 1'b1);
            m.stop();
            settle("channel_six");
        end
        ra = 7'($random(seed));
        for (int r = 0; r < 2; r++) begin
            addr(2'h3, 1'b0, 1'b1);
            m.send({ra, 1'b0}, 8, a);
            addr(2'h3, 1'b1, 1'b1);
            if (r == 0) begin
                m.send(8'hff, 4, a);
            end else begin
                m.recv(1'b0, b);
                cmp("read_hi", 23'(rd_val(ra) >> 8), 23'(b));
                m.recv(1'b0, b);
                cmp("read_lo", 23'(rd_val(ra) & 16'h00ff), 23'(b));
                m.recv(1'b1, b);
                cmp("read_extra", 23'h0, 23'(b));
            end
            m.stop();
        end
        settle("readback");
        results();
    end

    initial begin
        // about three times the length of a clean run, well under the cycle budget
        #600000;
        n_fail++;
        $display("[ERR] watchdog expected finish seen hang");
        results();
    end
endmodule

// File: verification/dis_master_model.sv
// dis_master_model.sv: behavioural i2c bus master for the slave link
// assumes sda is a pulled-up wire resolved outside from every pull-down
`timescale 1ns/1ps
module dis_master_model #(
    parameter int T_Q = 48
) (
    output logic      o_scl,
    output logic      o_sda_low,
    input  wire logic i_sda
);
    // ==========================================================
    // bus phases, scl stands high outside frames
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    // data moves mid-low only; sampled mid-high
    task automatic put_bit(input logic b, output logic r);
        #T_Q o_sda_low = !b;
        #(2*T_Q) o_scl = 1'b1;
        #(3*T_Q/2) r = i_sda;
        #(3*T_Q/2) o_scl = 1'b0;
    endtask

    task automatic start();
        #T_Q o_sda_low = 1'b0;
        #T_Q o_scl = 1'b1;
        #(2*T_Q) o_sda_low = 1'b1;
        #(2*T_Q) o_scl = 1'b0;
    endtask

    task automatic stop();
        #T_Q o_sda_low = 1'b1;
        #T_Q o_scl = 1'b1;
        #(2*T_Q) o_sda_low = 1'b0;
        #(3*T_Q);
    endtask

    // n below 8 cuts the byte short with no ack slot
    task automatic send(input logic [7:0] d, input int n, output logic ack);
        logic r;
        r = 1'b1;
        for (int i = 7; i > 7 - n; i--) put_bit(d[i], r);
        if (n == 8) put_bit(1'b1, r);
        ack = !r;
    endtask

    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(last, r);
    endtask
endmodule
